// file: chdma_engine.v
// Card to host transfer engine: buffer definition, commands, status and memory test
`timescale 1ns/1ps
`include "chdma_map.vh"
// How it works
// [RL1] Older families: page multiples or 16..2k
// [RL2] Older families: aux and stamp notify at least 2k
// [RL3] Newest family: 64..2k or pages; stamp 2k
// [RL4] Host supplies page aligned large buffer
// [RL5] Card to host overwrites host buffer
// [RL6] Standard mode starts at board offset
// [RL7] Length in bytes, within memory size
// [RL8] Newest family: length multiple of 64
// [RL9] Memory test: random access, card commands ignored
// [RL10] Buffer invalid on redefine, completion, request
// [RL11] Typed buffers; invalidate must match type
// [RL12] Aux only analog acq; stamp not replay
// [RL13] Transfer and card bits share command word
// [RL14] Start waits for trigger when acquiring; the engine waits for it in FIFO mode only
// [RL15] Wait ends on completion, block or timeout
// [RL16] Stop aborts, data becomes invalid
// [RL17] Block ready after each notify block
// [RL18] Complete flag only with zero notify
// [RL19] FIFO overrun or underrun sets flag
// [RL20] Internal fault sets error flag
// [RL21] Host should stop before invalidating
// [RL22] Zero notify signals once at end
// [RL23] Direction must match mode unless memtest
// [RL24] Start without valid buffer flags error
module chdma_engine #(
	parameter NEWEST_FAMILY = 0,
	parameter IS_ANALOG     = 1,
	parameter IS_REPLAY     = 0,
	parameter CYCLES_PER_MS = `CHDMA_CLK_MHZ * 1000
) (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [19:0] reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	output reg         reg_rvalid,
	output reg         wait_done,
	output reg  [15:0] card_cmd,
	output reg         card_cmd_valid,
	input  wire        trigger_seen,
	input  wire        fifo_mode,
	input  wire        fifo_fault,
	input  wire        mem_fault,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [63:0] mem_addr,
	output reg         host_req,
	output reg         host_we,
	output reg  [63:0] host_addr,
	input  wire        beat_ack,
	output reg         memtest_active
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_ARM  = 4'b0010;
	localparam ST_MOVE = 4'b0100;
	localparam ST_DONE = 4'b1000;
	localparam [63:0] BEAT = 64'h40;

	reg [3:0]  state;
	reg [31:0] def_type;
	reg [31:0] def_dir;
	reg [31:0] def_notify;
	reg [63:0] def_hostptr;
	reg [63:0] def_offset;
	reg [63:0] def_length;
	reg [63:0] mem_size;
	reg [31:0] timeout_ms;
	reg        buf_valid;
	reg [31:0] buf_type;
	reg        buf_dir;
	reg [31:0] buf_notify;
	reg [63:0] buf_len;
	reg [63:0] done_bytes;
	reg [31:0] block_bytes;
	reg        st_block;
	reg        st_done;
	reg        st_over;
	reg        st_err;
	reg        waiting;
	reg        arm_to;
	wire       notify_ok;
	wire       to_expired;

	chdma_notify_check u_chk (
		.notify        (reg_wdata),
		.buf_type      (def_type),
		.newest_family (NEWEST_FAMILY != 0),
		.legal         (notify_ok)
	);
	chdma_timeout #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_to (
		.core_clk (core_clk),
		.rst      (rst),
		.arm      (arm_to),
		.clear    (~waiting),
		.limit_ms (timeout_ms),
		.expired  (to_expired)
	);

	// Type exists on this kind of card
	function type_ok;
		input [31:0] t;
		begin
			type_ok = (t == `CHDMA_BUF_DATA)
				|| (t == `CHDMA_BUF_AUX && IS_ANALOG != 0 && IS_REPLAY == 0) // [RL12]
				|| (t == `CHDMA_BUF_STAMP && IS_REPLAY == 0); // [RL12]
		end
	endfunction

	// Direction legal for mode
	function dir_ok;
		input [31:0] d;
		input        mt;
		begin
			if (d == `CHDMA_DIR_TO_CARD)
				dir_ok = mt || (IS_REPLAY != 0); // [RL23]
			else if (d == `CHDMA_DIR_TO_HOST)
				dir_ok = mt || (IS_REPLAY == 0); // [RL23]
			else
				dir_ok = 1'b0;
		end
	endfunction

	wire len_ok = (def_length != 64'h0)
		&& (fifo_mode || (def_offset + def_length <= mem_size)) // [RL7]
		&& (NEWEST_FAMILY == 0 || def_length[5:0] == 6'h00); // [RL8]
	wire def_ok = type_ok(def_type) && dir_ok(def_dir, memtest_active) && len_ok;
	// Transfer bits stay live in memory test so either direction can move data
	wire wr_cmd = reg_wr && (reg_addr == `CHDMA_REG_CMD);
	wire wr_card = wr_cmd && !memtest_active; // [RL9]
	wire cmd_start = wr_cmd && reg_wdata[`CHDMA_BIT_START];
	wire cmd_wait  = wr_cmd && reg_wdata[`CHDMA_BIT_WAIT];
	wire cmd_stop  = wr_cmd && reg_wdata[`CHDMA_BIT_STOP];
	wire beat_go   = (state == ST_MOVE) && beat_ack;
	wire [63:0] next_done = done_bytes + BEAT;
	wire [31:0] next_block = block_bytes + BEAT[31:0];
	wire blk_hit = beat_go && (buf_notify != 32'h0) && (next_block >= buf_notify); // [RL17]
	wire last    = beat_go && (next_done >= buf_len);
	wire invalid_rq = reg_wr && (reg_addr == `CHDMA_REG_INVALIDATE)
		&& buf_valid && (reg_wdata == buf_type); // [RL11]
	wire commit  = reg_wr && (reg_addr == `CHDMA_REG_DEF_COMMIT);

	// Definition and setup registers
	always @(posedge core_clk) begin
		if (rst) begin
			def_type    <= `CHDMA_BUF_DATA;
			def_dir     <= `CHDMA_DIR_TO_HOST;
			def_notify  <= 32'h0;
			def_hostptr <= 64'h0;
			def_offset  <= 64'h0;
			def_length  <= 64'h0;
			mem_size    <= 64'h0;
			timeout_ms  <= 32'h0;
			memtest_active <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
			`CHDMA_REG_DEF_TYPE: def_type <= reg_wdata;
			`CHDMA_REG_DEF_DIR: def_dir <= reg_wdata;
			`CHDMA_REG_DEF_NOTIFY: begin
				if (notify_ok)
					def_notify <= reg_wdata; // [RL1]
			end
			`CHDMA_REG_DEF_HOSTPTR: def_hostptr <= {32'h0, reg_wdata[31:12], 12'h000}; // [RL4]
			`CHDMA_REG_DEF_OFFSET: def_offset <= {32'h0, reg_wdata};
			`CHDMA_REG_DEF_LENGTH: def_length <= {32'h0, reg_wdata};
			`CHDMA_REG_MEMSIZE: mem_size <= {32'h0, reg_wdata};
			`CHDMA_REG_TIMEOUT: timeout_ms <= reg_wdata;
			`CHDMA_REG_MEMTEST: memtest_active <= reg_wdata[0]; // [RL9]
			default: ;
			endcase
		end
	end

	// Buffer validity, transfer state machine and data beats
	always @(posedge core_clk) begin
		if (rst) begin
			state      <= ST_IDLE;
			buf_valid  <= 1'b0;
			buf_type   <= `CHDMA_BUF_DATA;
			buf_dir    <= 1'b1;
			buf_notify <= 32'h0;
			buf_len    <= 64'h0;
			done_bytes <= 64'h0;
			block_bytes <= 32'h0;
			mem_req    <= 1'b0;
			mem_we     <= 1'b0;
			mem_addr   <= 64'h0;
			host_req   <= 1'b0;
			host_we    <= 1'b0;
			host_addr  <= 64'h0;
		end else begin
			if (commit) begin
				// New definition replaces the old one
				buf_valid  <= def_ok; // [RL10]
				buf_type   <= def_type;
				buf_dir    <= def_dir[0];
				buf_notify <= def_notify;
				buf_len    <= def_length;
				mem_addr   <= fifo_mode ? 64'h0 : def_offset; // [RL6]
				host_addr  <= def_hostptr;
				state      <= ST_IDLE;
				mem_req    <= 1'b0;
				host_req   <= 1'b0;
			end else if (invalid_rq) begin
				buf_valid <= 1'b0; // [RL10]
				state     <= ST_IDLE;
				mem_req   <= 1'b0;
				host_req  <= 1'b0;
			end else if (cmd_stop) begin
				state    <= ST_IDLE; // [RL16]
				buf_valid <= 1'b0; // [RL16]
				mem_req  <= 1'b0;
				host_req <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					if (cmd_start && buf_valid) begin
						done_bytes  <= 64'h0;
						block_bytes <= 32'h0;
						state       <= ST_ARM;
					end
				end
				ST_ARM: begin
					if (buf_dir == 1'b0 || trigger_seen || fifo_mode == 1'b0 || memtest_active) begin
						state    <= ST_MOVE; // [RL14]
						mem_req  <= 1'b1;
						mem_we   <= ~buf_dir;
						host_req <= 1'b1;
						host_we  <= buf_dir; // [RL5]
					end
				end
				ST_MOVE: begin
					if (mem_fault || fifo_fault) begin
						state    <= ST_IDLE;
						mem_req  <= 1'b0;
						host_req <= 1'b0;
					end else if (beat_go) begin
						done_bytes  <= next_done;
						block_bytes <= blk_hit ? 32'h0 : next_block;
						mem_addr    <= mem_addr + BEAT;
						host_addr   <= host_addr + BEAT;
						if (last) begin
							state    <= ST_DONE;
							mem_req  <= 1'b0;
							host_req <= 1'b0;
						end
					end
				end
				ST_DONE: begin
					buf_valid <= 1'b0; // [RL10]
					state     <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// Sticky status flags, cleared on a new start; a set wins
	always @(posedge core_clk) begin
		if (rst) begin
			st_block <= 1'b0;
			st_done  <= 1'b0;
			st_over  <= 1'b0;
			st_err   <= 1'b0;
		end else begin
			if (blk_hit)
				st_block <= 1'b1; // [RL17]
			else if (cmd_start || commit)
				st_block <= 1'b0;
			if (last && buf_notify == 32'h0)
				st_done <= 1'b1; // [RL18] [RL22]
			else if (cmd_start || commit)
				st_done <= 1'b0;
			if (state == ST_MOVE && fifo_mode && fifo_fault)
				st_over <= 1'b1; // [RL19]
			else if (cmd_start || commit)
				st_over <= 1'b0;
			if ((state == ST_MOVE && mem_fault) || (cmd_start && !buf_valid))
				st_err <= 1'b1; // [RL20] [RL24]
			else if (cmd_start || commit)
				st_err <= 1'b0;
		end
	end

	// Wait command: ends on block, completion, error or timeout
	always @(posedge core_clk) begin
		if (rst) begin
			waiting   <= 1'b0;
			arm_to    <= 1'b0;
			wait_done <= 1'b0;
		end else begin
			arm_to    <= 1'b0;
			wait_done <= 1'b0;
			if (cmd_wait && !waiting) begin
				waiting <= 1'b1;
				arm_to  <= 1'b1;
			end else if (waiting && (blk_hit || st_block || state == ST_DONE
				|| st_err || st_over || cmd_stop || to_expired || !buf_valid)) begin
				waiting   <= 1'b0; // [RL15]
				wait_done <= 1'b1;
			end
		end
	end

	// Card control bits forwarded with the transfer bits of one write, except while the memory test runs
	always @(posedge core_clk) begin
		if (rst) begin
			card_cmd       <= 16'h0000;
			card_cmd_valid <= 1'b0;
		end else begin
			card_cmd_valid <= wr_card && (reg_wdata[15:0] != 16'h0000); // [RL13]
			card_cmd       <= wr_card ? reg_wdata[15:0] : 16'h0000; // [RL13]
		end
	end

	// Register read port; write-only locations read zero
	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata  <= 32'h0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			reg_rdata  <= 32'h0;
			if (reg_rd) begin
				case (reg_addr)
				`CHDMA_REG_STATUS: begin
					reg_rdata[`CHDMA_BIT_BLOCK_READY] <= st_block;
					reg_rdata[`CHDMA_BIT_COMPLETE]    <= st_done;
					reg_rdata[`CHDMA_BIT_OVERRUN]     <= st_over;
					reg_rdata[`CHDMA_BIT_ERROR]       <= st_err;
				end
				`CHDMA_REG_DEF_NOTIFY: reg_rdata <= def_notify;
				`CHDMA_REG_DEF_LENGTH: reg_rdata <= def_length[31:0];
				`CHDMA_REG_MEMSIZE: reg_rdata <= mem_size[31:0];
				`CHDMA_REG_TIMEOUT: reg_rdata <= timeout_ms;
				default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end
endmodule

// file: chdma_map.vh
// Register offsets, field positions, codes and timing counts of the transfer engine
`ifndef CHDMA_MAP_VH
`define CHDMA_MAP_VH
`define CHDMA_REG_CMD          20'h00064
`define CHDMA_REG_STATUS       20'h0006E
`define CHDMA_REG_MEMTEST      20'h30FFC
`define CHDMA_REG_DEF_TYPE     20'h00100
`define CHDMA_REG_DEF_DIR      20'h00104
`define CHDMA_REG_DEF_NOTIFY   20'h00108
`define CHDMA_REG_DEF_HOSTPTR  20'h0010C
`define CHDMA_REG_DEF_OFFSET   20'h00110
`define CHDMA_REG_DEF_LENGTH   20'h00114
`define CHDMA_REG_DEF_COMMIT   20'h00118
`define CHDMA_REG_INVALIDATE   20'h0011C
`define CHDMA_REG_MEMSIZE      20'h00120
`define CHDMA_REG_TIMEOUT      20'h00124
`define CHDMA_BIT_START        16
`define CHDMA_BIT_WAIT         17
`define CHDMA_BIT_STOP         18
`define CHDMA_BIT_BLOCK_READY  8
`define CHDMA_BIT_COMPLETE     9
`define CHDMA_BIT_OVERRUN      10
`define CHDMA_BIT_ERROR        11
`define CHDMA_BUF_DATA         32'h000003E8
`define CHDMA_BUF_AUX          32'h000007D0
`define CHDMA_BUF_STAMP        32'h00000BB8
`define CHDMA_DIR_TO_CARD      32'h00000000
`define CHDMA_DIR_TO_HOST      32'h00000001
`define CHDMA_PAGE_BYTES       32'h00001000
`define CHDMA_WORD_BYTES       32'h00000040
`define CHDMA_MIN_SUB_OLD      32'h00000010
`define CHDMA_MIN_SUB_NEW      32'h00000040
`define CHDMA_MIN_AUX          32'h00000800
`define CHDMA_TIMEOUT_MS       32'd1000
`define CHDMA_CLK_MHZ          32'd200
`endif

// file: chdma_notify_check.v
// Legality check of a notify size against buffer type and card family
`timescale 1ns/1ps
`include "chdma_map.vh"
module chdma_notify_check (
	input  wire [31:0] notify,
	input  wire [31:0] buf_type,
	input  wire        newest_family,
	output wire        legal
);
	// Single bit set in the sub-page range
	function is_pow2_sub;
		input [31:0] v;
		input [31:0] lo;
		begin
			is_pow2_sub = (v >= lo) && (v < `CHDMA_PAGE_BYTES) && ((v & (v - 32'h1)) == 32'h0);
		end
	endfunction
	wire page_mult = (notify[11:0] == 12'h000);
	wire sub_ok    = is_pow2_sub(notify, newest_family ? `CHDMA_MIN_SUB_NEW
		: `CHDMA_MIN_SUB_OLD);
	wire aux_ok    = (notify == 32'h0) || page_mult || (notify == `CHDMA_MIN_AUX);
	// Zero means end-only notification and is always accepted
	assign legal = (buf_type == `CHDMA_BUF_DATA) ? (notify == 32'h0 || page_mult || sub_ok)
		: aux_ok; // [RL1] [RL2] [RL3]
endmodule

// file: chdma_timeout.v
// Millisecond timeout counter for the wait command
`timescale 1ns/1ps
`include "chdma_map.vh"
module chdma_timeout #(
	parameter CYCLES_PER_MS = 200000
) (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        arm,
	input  wire        clear,
	input  wire [31:0] limit_ms,
	output reg         expired
);
	reg [31:0] cyc;
	reg [31:0] ms;
	reg        run;
	// One enable pulse per millisecond, count of pulses against the limit
	always @(posedge core_clk) begin
		if (rst || clear) begin
			cyc     <= 32'h0;
			ms      <= 32'h0;
			run     <= 1'b0;
			expired <= 1'b0;
		end else if (arm) begin
			cyc     <= 32'h0;
			ms      <= 32'h0;
			run     <= (limit_ms != 32'h0);
			expired <= 1'b0;
		end else if (run) begin
			if (cyc == CYCLES_PER_MS - 1) begin
				cyc <= 32'h0;
				ms  <= ms + 32'h1;
				if (ms + 32'h1 >= limit_ms) begin
					expired <= 1'b1;
					run     <= 1'b0;
				end
			end else begin
				cyc <= cyc + 32'h1;
			end
		end
	end
endmodule

// file: chdma_host_model.sv
// Host memory side of the transfer engine: beat acknowledge, beat count and first address capture
`timescale 1ns/1ps
module chdma_host_model (
	input  logic        core_clk,
	input  logic        rst,
	input  logic        slow,
	input  logic        clr,
	input  logic        host_req,
	input  logic        mem_req,
	input  logic [63:0] host_addr,
	input  logic [63:0] mem_addr,
	output logic        beat_ack = 1'b0,
	output logic [15:0] beats,
	output logic [63:0] first_addr,
	output logic [63:0] first_mem
);
	logic mseen;
	// Ack every cycle, or every other cycle when slow; count acknowledged host beats in either direction
	always @(posedge core_clk) begin
		beat_ack <= !rst && (host_req || mem_req) && !(slow && beat_ack);
		if (rst || clr) begin
			beats <= 16'h0000;
			mseen <= 1'b0;
		end else begin
			if (host_req && beat_ack) begin
				beats <= beats + 16'h0001;
				if (beats == 16'h0000)
					first_addr <= host_addr;
			end
			if (mem_req && beat_ack && !mseen) begin
				first_mem <= mem_addr;
				mseen <= 1'b1;
			end
		end
	end
endmodule

// file: chdma_engine_asserts.sv
// Port level checks of the transfer engine
`timescale 1ns/1ps
`include "chdma_map.vh"
module chdma_engine_chk (
	input logic        core_clk,
	input logic        rst,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [19:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic        reg_rvalid,
	input logic [15:0] card_cmd,
	input logic        card_cmd_valid,
	input logic        trigger_seen,
	input logic        fifo_mode,
	input logic        beat_ack,
	input logic        host_req,
	input logic        mem_req,
	input logic [63:0] host_addr,
	input logic [63:0] mem_addr,
	input logic        memtest_active
);
	logic [15:0] last_cmd;
	logic        cmd_wr;
	logic        mt_wr;
	// Command and memory test writes
	assign cmd_wr = reg_wr && reg_addr == `CHDMA_REG_CMD;
	assign mt_wr  = reg_wr && reg_addr == `CHDMA_REG_MEMTEST;
	// Low bits of the last command write
	always @(posedge core_clk)
		if (cmd_wr)
			last_cmd <= reg_wdata[15:0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without read");
	chk_memtest_on: assert property (
		mt_wr && reg_wdata == 32'h00000001 |-> ##[1:2] memtest_active)
		else $error("memory test not entered");
	chk_memtest_off: assert property (
		mt_wr && reg_wdata == 32'h00000000 |-> ##[1:2] !memtest_active)
		else $error("memory test not left");
	chk_memtest_quiet: assert property (
		cmd_wr && memtest_active |=> !card_cmd_valid [*2])
		else $error("card command passed in memory test");
	chk_card_cmd: assert property (
		cmd_wr && !memtest_active && reg_wdata[15:0] != 16'h0000
		|-> ##[1:2] (card_cmd_valid && card_cmd == last_cmd))
		else $error("card command bits lost");
	chk_host_step: assert property (
		host_req && beat_ack ##1 host_req |-> host_addr == $past(host_addr) + 64'h40)
		else $error("host address step wrong");
	chk_host_hold: assert property (
		host_req && !beat_ack ##1 host_req |-> $stable(host_addr))
		else $error("host address moved without ack");
	chk_mem_step: assert property (
		mem_req && beat_ack ##1 mem_req |-> mem_addr == $past(mem_addr) + 64'h40)
		else $error("board address step wrong");
	chk_trig_hold: assert property (
		fifo_mode && !trigger_seen && !host_req |=> !host_req)
		else $error("transfer began before trigger");
	chk_stop_ends: assert property (
		cmd_wr && reg_wdata[`CHDMA_BIT_STOP] && !memtest_active
		|-> ##[1:4] (!host_req [*4]))
		else $error("stop did not end transfer");
	cover property (host_req && beat_ack);
	cover property (cmd_wr && reg_wdata[`CHDMA_BIT_STOP]);
	cover property (cmd_wr && memtest_active);
endmodule
bind chdma_engine chdma_engine_chk chk (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
	.card_cmd(card_cmd), .card_cmd_valid(card_cmd_valid), .trigger_seen(trigger_seen),
	.fifo_mode(fifo_mode), .beat_ack(beat_ack), .host_req(host_req), .mem_req(mem_req),
	.host_addr(host_addr), .mem_addr(mem_addr), .memtest_active(memtest_active));

// file: chdma_engine_bench.sv
// Self-checking bench of the card to host transfer engine
`timescale 1ns/1ps
`include "chdma_map.vh"
module chdma_engine_bench;
	localparam logic [31:0] START = 32'h00010000;
	localparam logic [31:0] WAITC = 32'h00020000;
	localparam logic [31:0] STOP  = 32'h00040000;
	localparam logic [31:0] HOST  = `CHDMA_DIR_TO_HOST;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [19:0] reg_addr = 20'h00000;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        trigger_seen = 1'b1;
	logic        fifo_mode = 1'b0;
	logic        fifo_fault = 1'b0;
	logic        mem_fault = 1'b0;
	logic        slow = 1'b0;
	logic        clr = 1'b0;
	logic        inj_fifo = 1'b0;
	logic        inj_mem = 1'b0;
	logic [31:0] reg_rdata, st;
	logic [15:0] card_cmd, beats, card_seen;
	logic [63:0] mem_addr, host_addr, first_addr, first_mem;
	logic        reg_rvalid, wait_done, card_cmd_valid, mem_req, mem_we;
	logic        host_req, host_we, beat_ack, memtest_active;
	int          card_cnt = 0;
	int          wait_cnt = 0;
	int          fails = 0;
	int          check_count = 0;
	// Core clock
	initial forever #2.5 core_clk = ~core_clk;
	chdma_engine #(.CYCLES_PER_MS(10)) dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .wait_done(wait_done), .card_cmd(card_cmd),
		.card_cmd_valid(card_cmd_valid), .trigger_seen(trigger_seen), .fifo_mode(fifo_mode),
		.fifo_fault(fifo_fault), .mem_fault(mem_fault), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .host_req(host_req), .host_we(host_we), .host_addr(host_addr),
		.beat_ack(beat_ack), .memtest_active(memtest_active));
	chdma_host_model mdl (.core_clk(core_clk), .rst(rst), .slow(slow), .clr(clr),
		.host_req(host_req), .mem_req(mem_req), .host_addr(host_addr), .mem_addr(mem_addr),
		.beat_ack(beat_ack), .beats(beats), .first_addr(first_addr), .first_mem(first_mem));
	// Pulse capture and fault injection while data moves
	always @(posedge core_clk) begin
		if (card_cmd_valid === 1'b1) begin
			card_cnt++;
			card_seen = card_cmd;
		end
		if (wait_done === 1'b1)
			wait_cnt++;
	end
	always @(negedge core_clk) begin
		fifo_fault <= inj_fifo && host_req;
		mem_fault <= inj_mem && host_req;
	end
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [19:0] a);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		st = 32'hXXXXXXXX;
		@(negedge core_clk);
		reg_rd = 1'b0;
		repeat (3) begin
			if (reg_rvalid === 1'b1)
				st = reg_rdata;
			@(negedge core_clk);
		end
	endtask
	task automatic define(input logic [31:0] t, d, n, l);
		wr(`CHDMA_REG_DEF_TYPE, t);
		wr(`CHDMA_REG_DEF_DIR, d);
		wr(`CHDMA_REG_DEF_NOTIFY, n);
		wr(`CHDMA_REG_DEF_HOSTPTR, 32'h00002000);
		wr(`CHDMA_REG_DEF_OFFSET, 32'h00000080);
		wr(`CHDMA_REG_DEF_LENGTH, l);
		wr(`CHDMA_REG_DEF_COMMIT, 32'h00000001);
		clr = 1'b1;
		@(negedge core_clk);
		clr = 1'b0;
	endtask
	task automatic settle(input logic [15:0] n);
		int i;
		i = 0;
		while (i < 900 && !((n == 16'hFFFF || beats === n) && host_req === 1'b0 && i > 12)) begin
			@(negedge core_clk);
			i++;
		end
		if (i == 900) begin
			fails++;
			complete_run();
		end
	endtask
	task automatic go(input logic [31:0] c, input logic [15:0] n, input logic [31:0] m, s);
		// Beat count restarts with every command
		clr = 1'b1;
		wr(`CHDMA_REG_CMD, c);
		clr = 1'b0;
		settle(n);
		if (n != 16'hFFFF)
			check("beats", beats, n);
		rd(`CHDMA_REG_STATUS);
		check("status", st & m, s);
	endtask
	task automatic t_basic;
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000100);
		go(START, 16'h0004, 32'h00000B00, 32'h00000200);
		check("host base", first_addr, 64'h2000);
		check("board base", first_mem, 64'h80);
		check("to host", {host_we, mem_we}, 2'b10);
		go(START, 16'h0000, 32'h00000800, 32'h00000800);
	endtask
	task automatic t_notify;
		logic [31:0] bt [3] = '{`CHDMA_BUF_DATA, `CHDMA_BUF_DATA, `CHDMA_BUF_STAMP};
		logic [31:0] bn [3] = '{32'h00000030, 32'h00000008, 32'h00000400};
		define(`CHDMA_BUF_DATA, HOST, 32'h00000040, 32'h00000100);
		go(START, 16'h0004, 32'h00000300, 32'h00000100);
		for (int k = 0; k < 3; k++) begin
			define(bt[k], HOST, 0, 32'h00000800);
			wr(`CHDMA_REG_DEF_NOTIFY, bn[k]);
			rd(`CHDMA_REG_DEF_NOTIFY);
			check("notify kept", st, 32'h00000000);
			wr(`CHDMA_REG_DEF_COMMIT, 32'h00000001);
			go(START, 16'h0020, 32'h00000300, 32'h00000200);
		end
	endtask
	task automatic t_fifo;
		fifo_mode = 1'b1;
		trigger_seen = 1'b0;
		wr(`CHDMA_REG_TIMEOUT, 32'h00000001);
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000100);
		wait_cnt = 0;
		wr(`CHDMA_REG_CMD, START);
		wr(`CHDMA_REG_CMD, WAITC);
		repeat (4) @(negedge core_clk);
		check("wait early", wait_cnt, 0);
		repeat (36) @(negedge core_clk);
		check("wait timeout", wait_cnt, 1);
		check("held beats", beats, 16'h0000);
		trigger_seen = 1'b1;
		settle(16'h0004);
		check("released beats", beats, 16'h0004);
		// Fault arrives before the first acknowledge, so no beat lands
		inj_fifo = 1'b1;
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000100);
		go(START, 16'h0000, 32'h00000400, 32'h00000400);
		inj_fifo = 1'b0;
		fifo_mode = 1'b0;
	endtask
	task automatic t_stop;
		slow = 1'b1;
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00001000);
		wr(`CHDMA_REG_CMD, START);
		repeat (20) @(negedge core_clk);
		wr(`CHDMA_REG_CMD, STOP);
		repeat (8) @(negedge core_clk);
		check("stopped", host_req, 1'b0);
		check("partial", beats < 16'd64, 1'b1);
		wr(`CHDMA_REG_INVALIDATE, `CHDMA_BUF_DATA);
		go(START, 16'hFFFF, 32'h00000800, 32'h00000800);
		slow = 1'b0;
	endtask
	task automatic t_inval;
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000100);
		wr(`CHDMA_REG_INVALIDATE, `CHDMA_BUF_STAMP);
		go(START, 16'h0004, 32'h00000800, 32'h00000000);
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000100);
		wr(`CHDMA_REG_INVALIDATE, `CHDMA_BUF_DATA);
		go(START, 16'h0000, 32'h00000800, 32'h00000800);
		define(`CHDMA_BUF_DATA, `CHDMA_DIR_TO_CARD, 0, 32'h00000100);
		go(START, 16'h0000, 32'h00000800, 32'h00000800);
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00020000);
		go(START, 16'h0000, 32'h00000800, 32'h00000800);
	endtask
	task automatic t_fault;
		inj_mem = 1'b1;
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000400);
		go(START, 16'hFFFF, 32'h00000800, 32'h00000800);
		inj_mem = 1'b0;
	endtask
	task automatic t_memtest;
		wr(`CHDMA_REG_MEMTEST, 32'h00000001);
		check("memtest on", memtest_active, 1'b1);
		// Opposite direction is only legal while the memory test runs
		define(`CHDMA_BUF_DATA, `CHDMA_DIR_TO_CARD, 0, 32'h00000100);
		card_cnt = 0;
		go(START | 32'h00000004, 16'h0004, 32'h00000F00, 32'h00000200);
		check("card cmd ignored", card_cnt, 0);
		check("to card", {host_we, mem_we}, 2'b01);
		wr(`CHDMA_REG_MEMTEST, 32'h00000000);
		check("memtest off", memtest_active, 1'b0);
		define(`CHDMA_BUF_DATA, HOST, 0, 32'h00000100);
		go(START | 32'h00000004, 16'h0004, 32'h00000200, 32'h00000200);
		check("card cmd", card_seen, 16'h0004);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		check("idle", {host_req, mem_req, memtest_active, card_cmd_valid, wait_done}, 0);
		wr(`CHDMA_REG_MEMSIZE, 32'h00010000);
		t_basic();
		t_notify();
		t_fifo();
		t_stop();
		t_inval();
		t_fault();
		t_memtest();
		complete_run();
	end
endmodule
